// ### hw/peripheral_proc_op_execute.sv
// peripheral processor executor for operation codes 00 through 23
// assumes a local memory answering a read one cycle after the request
//
// Notes on behaviour
// - one-word and two-word instructions, trailing operand word
// - opcode 00 is a pass
// - long jump to trailing word, plus indexed word when d is nonzero
// - return jump stores P+2, resumes target+1
// - relative jump adds sign-extended short offset
// - taken relative jump with offset 00 or 77 hangs processor
// - zero jump only on positive zero
// - plus jump when sign bit clear
// - minus jump when sign bit set
// - shift left circular or right end-off
// - short xor touches low six bits only
// - short and clears upper twelve bits
// - selective clear of low six bits
// - short load zero-extended
// - short load inverted, upper bits ones
// - add unsigned short operand
// - subtract unsigned short operand
// - wide load from short and trailing word
// - wide add of eighteen-bit immediate
// - wide and with eighteen-bit immediate
// - wide xor with eighteen-bit immediate
// - memory addresses wrap from 7777 to 0000
`timescale 1ns/1ns
`default_nettype none
`include "pp_exec_params.svh"

module peripheral_proc_op_execute
  import pp_exec_pkg::*;
(
  input wire logic clk,                         // instruction clock
  input wire logic resetn,                      // deadstart, active low
  output logic mem_rd,                          // memory read strobe
  output logic mem_wr,                          // memory write strobe
  output logic [`ADDR_W-1:0] mem_addr,          // memory word address
  output logic [`ADDR_W-1:0] mem_wdata,         // memory write data
  input wire logic [`ADDR_W-1:0] mem_rdata,     // read data, next cycle
  output logic [`ACC_W-1:0] acc,                // accumulator contents
  output logic [`ADDR_W-1:0] pc,                // program address
  output logic hung,                            // stopped until deadstart
  output logic instr_done                       // pulse per instruction
);

  // ================================================================
  // state
  exec_state_t state_r, state_nxt;
  logic [`ADDR_W-1:0] p_r, p_nxt;
  logic [`ACC_W-1:0] acc_r, acc_nxt;
  logic [`ADDR_W-1:0] ir_r, ir_nxt;
  logic [`ADDR_W-1:0] m_r, m_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic [`ADDR_W-1:0] addr_r, addr_nxt;
  logic [`ADDR_W-1:0] wdata_r, wdata_nxt;
  logic done_r, done_nxt;

  // ================================================================
  // field decode: the word in hand is live read data while decoding
  logic [`ADDR_W-1:0] ins;
  logic [5:0] op;
  logic [5:0] d;
  logic [`ACC_W-1:0] short_ext;
  logic [`ACC_W-1:0] wide_imm;
  assign ins = (state_r == ST_DECODE) ? mem_rdata : ir_r;
  assign op = ins[11:6];
  assign d = ins[5:0];
  assign short_ext = {`UPPER_ZERO, d};
  assign wide_imm = {d, mem_rdata};

  // ================================================================
  // addresses: 12-bit sums wrap naturally past 7777
  logic [`ADDR_W-1:0] p_plus1;
  logic [`ADDR_W-1:0] p_plus2;
  logic [`ADDR_W-1:0] rel_target;
  logic [`ADDR_W-1:0] idx_target;
  assign p_plus1 = p_r + `PC_STEP_ONE;
  assign p_plus2 = p_r + `PC_STEP_TWO;
  assign rel_target = p_r + {{6{d[5]}}, d};
  assign idx_target = m_r + mem_rdata;

  // ================================================================
  // jump conditions; only +0 counts as zero, -0 is nonzero
  logic acc_zero;
  logic acc_neg;
  logic is_rel;
  logic take;
  logic hang_d;
  assign acc_zero = (acc_r == `ACC_RESET);
  assign acc_neg = acc_r[`ACC_W-1];
  assign is_rel = (op >= `OP_REL_JUMP) && (op <= `OP_MINUS_JUMP);
  assign hang_d = (d == `HANG_FWD) || (d == `HANG_BACK);
  assign take = (op == `OP_REL_JUMP) ||
                ((op == `OP_ZERO_JUMP) && acc_zero) ||
                ((op == `OP_NONZERO_JUMP) && !acc_zero) ||
                ((op == `OP_PLUS_JUMP) && !acc_neg) ||
                ((op == `OP_MINUS_JUMP) && acc_neg);

  // ================================================================
  // arithmetic: one adder serves short add and subtract and wide add
  logic [`ACC_W-1:0] add_x;
  logic [`ACC_W-1:0] add_b;
  logic [`ACC_W-1:0] add_sum;
  logic [`ACC_W-1:0] shift_out;
  assign add_x = op[4] ? wide_imm : short_ext;
  assign add_b = (op == `OP_SHORT_SUB) ? ~add_x : add_x;

  ones_comp_adder #(.W(`ACC_W)) u_adder (
    .a(acc_r),
    .b(add_b),
    .sum(add_sum)
  );

  acc_rotate_shifter #(.W(`ACC_W)) u_shifter (
    .a(acc_r),
    .count(d),
    .shifted(shift_out)
  );

  // ================================================================
  // short-operand results, selected while decoding
  logic [`ACC_W-1:0] short_res;
  logic is_short;
  assign is_short = (op >= `OP_ACC_SHIFT) && (op <= `OP_SHORT_SUB);
  always_comb begin
    case (op)
      `OP_ACC_SHIFT: short_res = shift_out;
      `OP_SHORT_XOR: short_res = {acc_r[17:6], acc_r[5:0] ^ d};
      `OP_SHORT_AND: short_res = {`UPPER_ZERO, acc_r[5:0] & d};
      `OP_SELECTIVE_CLEAR:
        short_res = {acc_r[17:6], acc_r[5:0] & ~d};
      `OP_SHORT_LOAD: short_res = short_ext;
      `OP_SHORT_LOAD_INV: short_res = ~short_ext;
      `OP_SHORT_ADD: short_res = add_sum;
      `OP_SHORT_SUB: short_res = add_sum;
      default: short_res = acc_r;
    endcase
  end

  // ================================================================
  // wide-operand results, selected once the trailing word arrives
  logic [`ACC_W-1:0] wide_res;
  always_comb begin
    case (op)
      `OP_WIDE_LOAD: wide_res = wide_imm;
      `OP_WIDE_ADD: wide_res = add_sum;
      `OP_WIDE_AND: wide_res = acc_r & wide_imm;
      `OP_WIDE_XOR: wide_res = acc_r ^ wide_imm;
      default: wide_res = acc_r;
    endcase
  end

  // ================================================================
  // sequencer; memory strobes are registered so they never glitch
  always_comb begin
    state_nxt = state_r;
    p_nxt = p_r;
    acc_nxt = acc_r;
    ir_nxt = ir_r;
    m_nxt = m_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    done_nxt = 1'b0;
    case (state_r)
      ST_START: begin
        rd_nxt = 1'b1;
        addr_nxt = p_r;
        state_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        state_nxt = ST_DECODE;
      end
      ST_DECODE: begin
        ir_nxt = ins;
        if ((op == `OP_LONG_JUMP) || (op == `OP_RETURN_JUMP) ||
            (op[5:2] == 4'h4)) begin
          // two-word forms fetch the trailing word at P+1
          rd_nxt = 1'b1;
          addr_nxt = p_plus1;
          state_nxt = ST_TRAIL_RQ;
        end else if (is_rel && take && hang_d) begin
          state_nxt = ST_HUNG;
        end else begin
          if (is_rel && take) begin
            p_nxt = rel_target;
          end else begin
            p_nxt = p_plus1;
          end
          if (is_short) begin
            acc_nxt = short_res;
          end
          done_nxt = 1'b1;
          rd_nxt = 1'b1;
          addr_nxt = (is_rel && take) ? rel_target : p_plus1;
          state_nxt = ST_FETCH;
        end
      end
      ST_TRAIL_RQ: begin
        state_nxt = ST_TRAIL;
      end
      ST_TRAIL: begin
        m_nxt = mem_rdata;
        if (op[4]) begin
          acc_nxt = wide_res;
          p_nxt = p_plus2;
          done_nxt = 1'b1;
          rd_nxt = 1'b1;
          addr_nxt = p_plus2;
          state_nxt = ST_FETCH;
        end else if (d != `HANG_FWD) begin
          // index word lives at address d
          rd_nxt = 1'b1;
          addr_nxt = {`FIELD_W'h00, d};
          state_nxt = ST_INDEX_RQ;
        end else if (op == `OP_RETURN_JUMP) begin
          wr_nxt = 1'b1;
          addr_nxt = mem_rdata;
          wdata_nxt = p_plus2;
          p_nxt = mem_rdata + `PC_STEP_ONE;
          state_nxt = ST_STORE;
        end else begin
          p_nxt = mem_rdata;
          done_nxt = 1'b1;
          rd_nxt = 1'b1;
          addr_nxt = mem_rdata;
          state_nxt = ST_FETCH;
        end
      end
      ST_INDEX_RQ: begin
        state_nxt = ST_INDEX;
      end
      ST_INDEX: begin
        if (op == `OP_RETURN_JUMP) begin
          wr_nxt = 1'b1;
          addr_nxt = idx_target;
          wdata_nxt = p_plus2;
          p_nxt = idx_target + `PC_STEP_ONE;
          state_nxt = ST_STORE;
        end else begin
          p_nxt = idx_target;
          done_nxt = 1'b1;
          rd_nxt = 1'b1;
          addr_nxt = idx_target;
          state_nxt = ST_FETCH;
        end
      end
      ST_STORE: begin
        done_nxt = 1'b1;
        rd_nxt = 1'b1;
        addr_nxt = p_r;
        state_nxt = ST_FETCH;
      end
      ST_HUNG: begin
        state_nxt = ST_HUNG;
      end
      default: begin
        state_nxt = ST_START;
      end
    endcase
  end

  // ================================================================
  // registers; deadstart is the only way out of the hung state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= ST_START;
      p_r <= `PC_RESET;
      acc_r <= `ACC_RESET;
      ir_r <= `UPPER_ZERO;
      m_r <= `UPPER_ZERO;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= `UPPER_ZERO;
      wdata_r <= `UPPER_ZERO;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      p_r <= p_nxt;
      acc_r <= acc_nxt;
      ir_r <= ir_nxt;
      m_r <= m_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      done_r <= done_nxt;
    end
  end

  // ================================================================
  // outputs
  assign mem_rd = rd_r;
  assign mem_wr = wr_r;
  assign mem_addr = addr_r;
  assign mem_wdata = wdata_r;
  assign acc = acc_r;
  assign pc = p_r;
  assign hung = (state_r == ST_HUNG);
  assign instr_done = done_r;

  // ================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic dec;
  assign dec = (state_r == ST_DECODE);

  chk_pass_advance: assert property (
    dec && op == `OP_PASS |=> p_r == $past(p_r) + `PC_STEP_ONE &&
      acc_r == $past(acc_r) ##1 mem_rd == 1'b0)
    else $error("pass did not advance by one");
  chk_hang_rel: assert property (
    dec && op == `OP_REL_JUMP && hang_d |=> hung [*4])
    else $error("relative jump 00 or 77 did not hang");
  chk_zero_jump: assert property (
    dec && op == `OP_ZERO_JUMP && acc_r != `ACC_RESET |=>
      p_r == $past(p_r) + `PC_STEP_ONE)
    else $error("zero jump taken on nonzero");
  chk_plus_jump: assert property (
    dec && op == `OP_PLUS_JUMP && !acc_r[17] && !hang_d |=>
      p_r == $past(rel_target))
    else $error("plus jump not taken");
  chk_minus_skip: assert property (
    dec && op == `OP_MINUS_JUMP && !acc_r[17] |=>
      p_r == $past(p_r) + `PC_STEP_ONE)
    else $error("minus jump taken on positive");
  chk_xor_upper: assert property (
    dec && op == `OP_SHORT_XOR |=> acc_r[17:6] == $past(acc_r[17:6]))
    else $error("short xor changed upper bits");
  chk_load_inv: assert property (
    dec && op == `OP_SHORT_LOAD_INV |=>
      acc_r == ~{`UPPER_ZERO, $past(d)})
    else $error("inverted load wrong");
  chk_trail_fetch: assert property (
    dec && op == `OP_WIDE_LOAD |=> mem_rd && mem_addr == $past(p_plus1)
      ##2 instr_done && acc_r[17:12] == $past(d, 3))
    else $error("wide load trailing fetch wrong");
  chk_return_store: assert property (
    state_r == ST_STORE |-> mem_wr && mem_addr == p_r - `PC_STEP_ONE)
    else $error("return jump store misplaced");

  cov_pass: cover property (dec && op == `OP_PASS);
  cov_return: cover property (state_r == ST_STORE ##2 dec);
  cov_hang: cover property (dec && op == `OP_REL_JUMP ##1 hung);
  cov_wide_add: cover property (dec && op == `OP_WIDE_ADD ##3 instr_done);

endmodule

`default_nettype wire

// ### hw/pp_exec_params.svh
// constants for the peripheral processor short-opcode executor
// assumes 12-bit local memory words and an 18-bit accumulator
`ifndef PP_EXEC_PARAMS_SVH
`define PP_EXEC_PARAMS_SVH

// ==================================================================
// widths
`define ADDR_W 12
`define ACC_W 18
`define FIELD_W 6

// ==================================================================
// operation codes (upper field of the instruction word)
`define OP_PASS 6'h00
`define OP_LONG_JUMP 6'h01
`define OP_RETURN_JUMP 6'h02
`define OP_REL_JUMP 6'h03
`define OP_ZERO_JUMP 6'h04
`define OP_NONZERO_JUMP 6'h05
`define OP_PLUS_JUMP 6'h06
`define OP_MINUS_JUMP 6'h07
`define OP_ACC_SHIFT 6'h08
`define OP_SHORT_XOR 6'h09
`define OP_SHORT_AND 6'h0A
`define OP_SELECTIVE_CLEAR 6'h0B
`define OP_SHORT_LOAD 6'h0C
`define OP_SHORT_LOAD_INV 6'h0D
`define OP_SHORT_ADD 6'h0E
`define OP_SHORT_SUB 6'h0F
`define OP_WIDE_LOAD 6'h10
`define OP_WIDE_ADD 6'h11
`define OP_WIDE_AND 6'h12
`define OP_WIDE_XOR 6'h13

// ==================================================================
// relative-jump offsets that hang the processor
`define HANG_FWD 6'h00
`define HANG_BACK 6'h3F

// ==================================================================
// reset values and program counter steps
`define PC_RESET 12'h000
`define ACC_RESET 18'h00000
`define PC_STEP_ONE 12'h001
`define PC_STEP_TWO 12'h002
`define UPPER_ZERO 12'h000

`endif

// ### hw/pp_exec_pkg.sv
// types shared by the short-opcode executor
// assumes nothing beyond a SystemVerilog elaborator
package pp_exec_pkg;

  // ================================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_START,
    ST_FETCH,
    ST_DECODE,
    ST_TRAIL_RQ,
    ST_TRAIL,
    ST_INDEX_RQ,
    ST_INDEX,
    ST_STORE,
    ST_HUNG
  } exec_state_t;

endpackage

// ### hw/ones_comp_adder.sv
// ones' complement adder with end-around carry
// assumes the caller complements the second operand for a subtract
`timescale 1ns/1ns
`default_nettype none

module ones_comp_adder #(
  parameter int W = 18
) (
  input wire logic [W-1:0] a, // first operand
  input wire logic [W-1:0] b, // second operand
  output logic [W-1:0] sum    // ones' complement sum
);

  // ================================================================
  // carry out of the top bit folds back into the bottom
  logic [W:0] raw;
  assign raw = {1'b0, a} + {1'b0, b};
  assign sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};

endmodule

`default_nettype wire

// ### hw/acc_rotate_shifter.sv
// accumulator shifter: circular left or end-off right
// assumes a 6-bit count whose top bit selects the direction
`timescale 1ns/1ns
`default_nettype none

module acc_rotate_shifter #(
  parameter int W = 18
) (
  input wire logic [W-1:0] a,     // value to shift
  input wire logic [5:0] count,   // signed ones' complement count
  output logic [W-1:0] shifted    // shifted result
);

  // ================================================================
  // left counts beyond the width wrap around the word
  localparam logic [4:0] WIDTH_K = 5'(W);
  logic [4:0] left_k;
  logic [4:0] right_k;
  logic [2*W-1:0] doubled;
  assign left_k = count[4:0] % WIDTH_K;
  assign doubled = {a, a} << left_k;
  // complement of a negative count gives the right distance, 71 -> 6
  assign right_k = ~count[4:0];
  assign shifted = count[5] ? (a >> right_k) : doubled[2*W-1:W];

endmodule

`default_nettype wire

// ### test/pp_local_memory.sv
// behavioural local memory of 12-bit words for the executor's far side
// assumes strobes sampled on the rising edge and the bench preloading
// the words while the executor is held in deadstart
`timescale 1ns/1ns
`default_nettype none

module pp_local_memory (
  input wire logic clk,              // instruction clock
  input wire logic mem_rd,           // read strobe
  input wire logic mem_wr,           // write strobe
  input wire logic [11:0] mem_addr,  // word address
  input wire logic [11:0] mem_wdata, // write data
  output logic [11:0] mem_rdata      // read data, one cycle after strobe
);
  // ==================================================================
  // storage
  // twelve-bit words: instruction words never carry the top bit
  logic [11:0] words [0:4095];

  initial mem_rdata = 12'h000;

  // answer exactly one cycle after the strobe, then scramble the bus so
  // a late sample in the executor cannot pass on a stale word
  always @(posedge clk) begin
    if (mem_rd) begin
      mem_rdata <= words[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr) begin
      words[mem_addr] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the short-opcode executor
// assumes pp_local_memory on the memory port and a 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "pp_exec_params.svh"

module tb_top;
  localparam int MASK = 'h3FFFF;
  logic clk;
  logic resetn;
  logic mem_rd;
  logic mem_wr;
  logic [`ADDR_W-1:0] mem_addr;
  logic [`ADDR_W-1:0] mem_wdata;
  logic [`ADDR_W-1:0] mem_rdata;
  logic [`ACC_W-1:0] acc;
  logic [`ADDR_W-1:0] pc;
  logic hung;
  logic instr_done;
  logic [11:0] img [0:4095];
  logic [31:0] seed;
  int failures;
  int n_compared;
  int m_acc;
  int m_pc;
  bit m_hang;

  // ==================================================================
  // design and memory
  peripheral_proc_op_execute dut (.clk(clk), .resetn(resetn),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc), .pc(pc),
    .hung(hung), .instr_done(instr_done));
  pp_local_memory ppm (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  always #10 clk = ~clk;

  // ==================================================================
  // helpers
  task automatic check(string name, logic [17:0] seen, logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ones' complement add with end-around carry
  function automatic int oc_add(int a, int b);
    int s;
    s = a + b;
    if (s > MASK) s = (s & MASK) + 1;
    return s;
  endfunction

  // left counts wrap modulo the width; right counts past it clear
  function automatic int shift(int a, int d);
    int k;
    if (d < 32) begin
      k = d % 18;
      return ((a << k) | (a >> (18 - k))) & MASK;
    end
    k = (~d) & 31;
    return (k >= 18) ? 0 : (a >> k);
  endfunction

  // ==================================================================
  // reference model: one instruction at m_pc
  task automatic step(output int op, output int wa);
    int w, d, m, t, wide;
    bit take;
    w = img[m_pc];
    op = w >> 6;
    d = w & 63;
    m = img[(m_pc + 1) & 'hFFF];
    wide = (d << 12) | m;
    wa = -1;
    take = 0;
    case (op)
      `OP_LONG_JUMP, `OP_RETURN_JUMP: begin
        t = (d == 0) ? m : ((m + img[d]) & 'hFFF);
        if (op == `OP_RETURN_JUMP) begin
          img[t] = 12'((m_pc + 2) & 'hFFF);
          wa = t;
          t = t + 1;
        end
        m_pc = t & 'hFFF;
      end
      `OP_REL_JUMP: take = 1;
      `OP_ZERO_JUMP: take = (m_acc == 0);
      `OP_NONZERO_JUMP: take = (m_acc != 0);
      `OP_PLUS_JUMP: take = (m_acc < 'h20000);
      `OP_MINUS_JUMP: take = (m_acc >= 'h20000);
      `OP_ACC_SHIFT: m_acc = shift(m_acc, d);
      `OP_SHORT_XOR: m_acc = m_acc ^ d;
      `OP_SHORT_AND: m_acc = m_acc & d;
      `OP_SELECTIVE_CLEAR: m_acc = m_acc & ~d & MASK;
      `OP_SHORT_LOAD: m_acc = d;
      `OP_SHORT_LOAD_INV: m_acc = ~d & MASK;
      `OP_SHORT_ADD: m_acc = oc_add(m_acc, d);
      `OP_SHORT_SUB: m_acc = oc_add(m_acc, ~d & MASK);
      `OP_WIDE_LOAD: m_acc = wide;
      `OP_WIDE_ADD: m_acc = oc_add(m_acc, wide);
      `OP_WIDE_AND: m_acc = m_acc & wide;
      `OP_WIDE_XOR: m_acc = m_acc ^ wide;
      default: ;
    endcase
    if (op >= `OP_REL_JUMP && op <= `OP_MINUS_JUMP) begin
      if (take && (d == 0 || d == 63)) m_hang = 1;
      else if (take) m_pc = (m_pc + d + (d >= 32 ? 'hFC0 : 0)) & 'hFFF;
      else m_pc = (m_pc + 1) & 'hFFF;
    end else if (op >= `OP_WIDE_LOAD) begin
      m_pc = (m_pc + 2) & 'hFFF;
    end else if (op > `OP_RETURN_JUMP || op == `OP_PASS) begin
      m_pc = (m_pc + 1) & 'hFFF;
    end
  endtask

  // ==================================================================
  // deadstart, preload, then compare every completed instruction
  task automatic run_prog(int n);
    int op, wa, cyc, strobes;
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    check("reset state", 18'({hung, mem_rd, mem_wr, instr_done, pc}), 0);
    check("reset acc", acc, 18'h00000);
    for (int a = 0; a < 4096; a++) ppm.words[a] = img[a];
    resetn = 1'b1;
    m_pc = 0;
    m_acc = 0;
    m_hang = 0;
    for (int i = 0; i < n && !m_hang; i++) begin
      step(op, wa);
      cyc = 0;
      do begin
        @(negedge clk);
        cyc++;
      end while (!(m_hang ? hung === 1'b1 : instr_done === 1'b1) && cyc < 40);
      if (m_hang) begin
        check("hung", 18'(hung), 18'h1);
        strobes = 0;
        repeat (8) begin
          @(negedge clk);
          strobes += int'(mem_rd | mem_wr | instr_done);
        end
        check("hung strobes", 18'(strobes), 18'h0);
      end else begin
        check("done", 18'(instr_done), 18'h1);
        if (op >= `OP_WIDE_LOAD) begin
          check("wide acc", acc, 18'(m_acc));
        end else if (op >= `OP_SHORT_ADD) begin
          check("add acc", acc, 18'(m_acc));
        end else if (op >= `OP_ACC_SHIFT) begin
          check("short acc", acc, 18'(m_acc));
        end else begin
          check("acc", acc, 18'(m_acc));
        end
        if (op < `OP_REL_JUMP) begin
          check("jump pc", 18'(pc), 18'(m_pc));
        end else if (op <= `OP_MINUS_JUMP) begin
          check("branch pc", 18'(pc), 18'(m_pc));
        end else begin
          check("pc", 18'(pc), 18'(m_pc));
        end
        if (wa >= 0) check("link", 18'(ppm.words[wa]), 18'(img[wa]));
      end
    end
  endtask

  task automatic put(int a, int op, int d);
    img[a] = 12'((op << 6) | d);
  endtask

  task automatic clear_img;
    for (int a = 0; a < 4096; a++) img[a] = 12'h000;
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==================================================================
  // main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    failures = 0;
    n_compared = 0;
    seed = 32'h8574;
    // negative zero through zero, nonzero and minus tests, right shift, return link, wrap
    clear_img();
    put(0, `OP_SHORT_LOAD_INV, 0);
    put(1, `OP_ZERO_JUMP, 2);
    put(2, `OP_NONZERO_JUMP, 2);
    put(4, `OP_MINUS_JUMP, 2);
    put(6, `OP_ACC_SHIFT, 'h39);
    put(7, `OP_PLUS_JUMP, 2);
    put(9, `OP_RETURN_JUMP, 'h20);
    img[10] = 12'hFEE;
    img['h20] = 12'h00F;
    put('hFFE, `OP_WIDE_XOR, 'h2A);
    img['hFFF] = 12'hA5C;
    run_prog(30);
    // add of opposites, untaken hang offset, taken zero offset hangs
    clear_img();
    put(0, `OP_SHORT_ADD, 5);
    put(1, `OP_SHORT_SUB, 5);
    put(2, `OP_ZERO_JUMP, 'h3F);
    put(3, `OP_NONZERO_JUMP, 0);
    run_prog(10);
    // backward jump across zero, then offset 77 hangs
    clear_img();
    put(0, `OP_REL_JUMP, 'h3E);
    put('hFFF, `OP_REL_JUMP, 'h3F);
    run_prog(10);
    // random programs; each new run is a deadstart, often mid-instruction
    for (int r = 0; r < 6; r++) begin
      for (int a = 0; a < 4096; a++) begin
        img[a] = 12'(((xs() % 20) << 6) | (xs() & 63));
      end
      run_prog(150);
    end
    stop_test();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
